// File: design/passthrough_i2c_remote_main_ctrl.sv
// Purpose: Remote main rate/time-out control, per-channel status, pin exchange and crossover
// Assumes: Link inputs are asynchronous; ack and packet-end events are taken on rising edges of the link clock
// Notes:   Rate, time-out, status, exchange and crossover; rules follow
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module passthrough_i2c_remote_main_ctrl #(
  parameter int RATE0_HALF_CYC = ptc_pkg::HALF0_CYC,
  parameter int TO_1MS_CYCLES  = ptc_pkg::TO_1MS_CYC
) (
  // Clock, reset, enable
  input  wire logic                          i_clk,
  input  wire logic                          i_reset,
  input  wire logic                          i_ce,
  // AXI4-Lite write
  input  wire logic                          i_axi_awvalid,
  output logic                               o_axi_awready,
  input  wire logic [7:0]                    i_axi_awaddr,
  input  wire logic                          i_axi_wvalid,
  output logic                               o_axi_wready,
  input  wire logic [31:0]                   i_axi_wdata,
  input  wire logic [3:0]                    i_axi_wstrb,
  output logic                               o_axi_bvalid,
  input  wire logic                          i_axi_bready,
  output logic [1:0]                         o_axi_bresp,
  // AXI4-Lite read
  input  wire logic                          i_axi_arvalid,
  output logic                               o_axi_arready,
  input  wire logic [7:0]                    i_axi_araddr,
  output logic                               o_axi_rvalid,
  input  wire logic                          i_axi_rready,
  output logic [31:0]                        o_axi_rdata,
  output logic [1:0]                         o_axi_rresp,
  // Link side
  input  wire logic                          i_link_clk,
  input  wire ptc_pkg::link_evt_type [1:0]   i_link_evt,
  // Pass-through pins
  input  wire ptc_pkg::i2c_line_type [1:0]   i_pin,
  output ptc_pkg::i2c_line_type [1:0]        o_pin_out,
  output ptc_pkg::i2c_line_type [1:0]        o_pin_oe_n,
  // Control channel lines
  input  wire ptc_pkg::i2c_line_type         i_cc_line,
  output ptc_pkg::i2c_line_type              o_cc_drive_n,
  // Internal channel main side
  input  wire ptc_pkg::i2c_line_type [1:0]   i_chan_drive_n,
  output ptc_pkg::i2c_line_type [1:0]        o_chan_line,
  // Remote main timing and events
  output logic                               o_main_bit_tick,
  output logic [1:0]                         o_bus_release,
  output logic                               o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Half bit period in clock cycles for a rate code
  function automatic logic [14:0] half_base(input logic [2:0] code);
    int bps;
    bps = ptc_pkg::RATE_BPS[code];
    if (code == 3'h0) begin
      half_base = 15'(RATE0_HALF_CYC);
    end else begin
      half_base = 15'((ptc_pkg::CLK_HZ + 2 * bps - 1) / (2 * bps));
    end
  endfunction

  // Time-out length in cycles for a selection code
  function automatic logic [22:0] to_limit(input logic [2:0] sel);
    if (sel == 3'h0) begin
      to_limit = 23'(ptc_pkg::TO_16US_CYC);
    end else begin
      to_limit = 23'(TO_1MS_CYCLES) << (sel - 3'h1);
    end
  endfunction

  // True for any mapped register word
  function automatic logic addr_known(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    addr_known = (w == ptc_pkg::ADDR_MAIN_CFG) || (w == ptc_pkg::ADDR_ROUTE) ||
                 (w == ptc_pkg::ADDR_STATUS) || (w == ptc_pkg::ADDR_IRQ_STATUS) ||
                 (w == ptc_pkg::ADDR_IRQ_MASK);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [2:0]                  rate_code;    // Remote main rate code
  logic                        rate_double;  // Remote main rate doubling
  logic [2:0]                  to_sel;       // Remote main time-out select
  logic                        exchange;     // Pin exchange
  logic [1:0]                  xover;        // Crossover per channel
  logic [1:0]                  pt_en;        // Channel enable
  logic [1:0]                  ack_inv;      // Inverted last acknowledge
  logic [1:0]                  ack_seen;     // Any acknowledge in last packet
  logic [1:0]                  to_flag;      // Time-out occurred
  logic [3:0]                  irq_status;   // Sticky events
  logic [3:0]                  irq_mask;     // Event enables
  logic [1:0]                  acc_seen;     // Acknowledge seen, packet in flight
  logic [1:0]                  acc_inv;      // Inverted last acknowledge in flight
  logic                        lclk_s1;      // Link clock synchroniser
  logic                        lclk_s2;
  logic                        lclk_s3;
  ptc_pkg::link_evt_type [1:0] evt_s1;       // Link event synchroniser
  ptc_pkg::link_evt_type [1:0] evt_s2;
  ptc_pkg::i2c_line_type [1:0] pin_s1;       // Pin synchroniser
  ptc_pkg::i2c_line_type [1:0] pin_s2;
  ptc_pkg::i2c_line_type       cc_s1;        // Control channel synchroniser
  ptc_pkg::i2c_line_type       cc_s2;
  ptc_pkg::to_state_type       to_state [2]; // Time-out watcher per channel
  logic [22:0]                 to_cnt [2];
  logic [14:0]                 rate_cnt;     // Bit-rate divider
  logic [7:0]                  aw_addr;      // Held write address
  logic [31:0]                 w_data;       // Held write data
  logic [3:0]                  w_strb;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and selection

  // Remote main rate; only this main sees the code, the local subordinate has its own
  wire  [14:0] half_raw  = half_base(rate_code);
  wire  [14:0] half_sel  = rate_double ? (half_raw >> 1) : half_raw;
  wire         rate_wrap = (rate_cnt == 15'h0);
  wire  [22:0] to_lim    = to_limit(to_sel);

  // Link edge found by the system clock; the first stage feeds only the second
  wire         link_edge = lclk_s2 & ~lclk_s3;
  wire  [1:0]  ack_ev    = {link_edge & evt_s2[1].ack_valid, link_edge & evt_s2[0].ack_valid};
  wire  [1:0]  end_ev    = {link_edge & evt_s2[1].pkt_end, link_edge & evt_s2[0].pkt_end};
  wire  [1:0]  waiting   = {evt_s2[1].wait_resp, evt_s2[0].wait_resp};

  // Time-out fires on the last counted cycle of a live wait
  wire  [1:0]  to_fire;
  wire  [1:0]  expired;
  assign to_fire[0] = (to_state[0] == ptc_pkg::TO_COUNT) && waiting[0] &&
                      (to_sel != ptc_pkg::TO_DISABLED) && (to_cnt[0] >= to_lim - 23'h1);
  assign to_fire[1] = (to_state[1] == ptc_pkg::TO_COUNT) && waiting[1] &&
                      (to_sel != ptc_pkg::TO_DISABLED) && (to_cnt[1] >= to_lim - 23'h1);
  assign expired    = {to_state[1] == ptc_pkg::TO_EXPIRED, to_state[0] == ptc_pkg::TO_EXPIRED};

  // Channel drive gating: disabled or timed-out channels let go of the lines
  wire  [1:0]  gate  = ~pt_en | expired;
  ptc_pkg::i2c_line_type [1:0] pin_n;
  ptc_pkg::i2c_line_type [1:0] cc_n;
  assign pin_n[0] = i_chan_drive_n[0] | {2{gate[0] | xover[0]}};
  assign pin_n[1] = i_chan_drive_n[1] | {2{gate[1] | xover[1]}};
  assign cc_n[0]  = i_chan_drive_n[0] | {2{gate[0] | ~xover[0]}};
  assign cc_n[1]  = i_chan_drive_n[1] | {2{gate[1] | ~xover[1]}};

  // Pin exchange; plain open-drain pass, no arbitration since one main owns each bus
  ptc_pkg::i2c_line_type [1:0] next_pin_oe_n;
  ptc_pkg::i2c_line_type [1:0] chan_pin;
  ptc_pkg::i2c_line_type [1:0] next_chan_line;
  assign next_pin_oe_n[0] = exchange ? pin_n[1] : pin_n[0];
  assign next_pin_oe_n[1] = exchange ? pin_n[0] : pin_n[1];
  assign chan_pin[0]      = exchange ? pin_s2[1] : pin_s2[0];
  assign chan_pin[1]      = exchange ? pin_s2[0] : pin_s2[1];
  assign next_chan_line[0] = xover[0] ? cc_s2 : chan_pin[0];
  assign next_chan_line[1] = xover[1] ? cc_s2 : chan_pin[1];
  wire ptc_pkg::i2c_line_type next_cc_drive_n = cc_n[0] & cc_n[1];

  // Register bus decode
  wire         ar_fire  = i_axi_arvalid & o_axi_arready;
  wire         aw_fire  = i_axi_awvalid & o_axi_awready;
  wire         w_fire   = i_axi_wvalid & o_axi_wready;
  wire         wr_go    = ~o_axi_awready & ~o_axi_wready & ~o_axi_bvalid;
  wire  [7:0]  aw_word  = {aw_addr[7:2], 2'b00};
  wire  [7:0]  ar_word  = {i_axi_araddr[7:2], 2'b00};
  wire         wr_byte0 = wr_go & w_strb[0];
  wire         wr_cfg   = wr_byte0 && (aw_word == ptc_pkg::ADDR_MAIN_CFG);
  wire         wr_route = wr_byte0 && (aw_word == ptc_pkg::ADDR_ROUTE);
  wire         wr_mask  = wr_byte0 && (aw_word == ptc_pkg::ADDR_IRQ_MASK);
  wire         rd_clear = ar_fire && (ar_word == ptc_pkg::ADDR_IRQ_STATUS);

  // Read words; layouts follow the package field positions
  wire  [31:0] cfg_word    = {25'h0, to_sel, rate_double, rate_code};
  wire  [31:0] route_word  = {27'h0, pt_en, xover, exchange};
  wire  [31:0] status_word = {25'h0, to_flag[1], ack_seen[1], ack_inv[1], 1'b0,
                              to_flag[0], ack_seen[0], ack_inv[0]};
  wire  [31:0] rd_word =
    (ar_word == ptc_pkg::ADDR_MAIN_CFG)   ? cfg_word :
    (ar_word == ptc_pkg::ADDR_ROUTE)      ? route_word :
    (ar_word == ptc_pkg::ADDR_STATUS)     ? status_word :
    (ar_word == ptc_pkg::ADDR_IRQ_STATUS) ? {28'h0, irq_status} :
    (ar_word == ptc_pkg::ADDR_IRQ_MASK)   ? {28'h0, irq_mask} : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers

  // Two stages for every outside input; edge detect reads only the second and third
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      {lclk_s1, lclk_s2, lclk_s3} <= 3'h0;
      evt_s1 <= '0;
      evt_s2 <= '0;
      pin_s1 <= '1;
      pin_s2 <= '1;
      cc_s1  <= '1;
      cc_s2  <= '1;
    end else if (i_ce) begin
      {lclk_s3, lclk_s2, lclk_s1} <= {lclk_s2, lclk_s1, i_link_clk};
      evt_s1 <= i_link_evt;
      evt_s2 <= evt_s1;
      pin_s1 <= i_pin;
      pin_s2 <= pin_s1;
      cc_s1  <= i_cc_line;
      cc_s2  <= cc_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Remote main bit clock

  // Divider reloads at each wrap; a code change lands at the next wrap
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rate_cnt        <= 15'h0;
      o_main_bit_tick <= 1'b0;
    end else if (i_ce) begin
      rate_cnt        <= rate_wrap ? half_sel - 15'h1 : rate_cnt - 15'h1;
      o_main_bit_tick <= rate_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response time-out watchers, one per channel

  // Counting stops when the response ends the wait; disabled code just holds
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int c = 0; c < 2; c++) begin
        to_state[c] <= ptc_pkg::TO_IDLE;
        to_cnt[c]   <= 23'h0;
      end
      o_bus_release <= 2'h0;
    end else if (i_ce) begin
      o_bus_release <= to_fire;
      for (int c = 0; c < 2; c++) begin
        case (to_state[c])
          ptc_pkg::TO_IDLE: begin
            to_cnt[c] <= 23'h0;
            if (waiting[c]) begin
              to_state[c] <= ptc_pkg::TO_COUNT;
            end
          end
          ptc_pkg::TO_COUNT: begin
            if (!waiting[c]) begin
              to_state[c] <= ptc_pkg::TO_IDLE;
            end else if (to_fire[c]) begin
              to_state[c] <= ptc_pkg::TO_EXPIRED;
            end else if (to_sel != ptc_pkg::TO_DISABLED) begin
              to_cnt[c] <= to_cnt[c] + 23'h1;
            end
          end
          ptc_pkg::TO_EXPIRED: begin
            if (!waiting[c]) begin
              to_state[c] <= ptc_pkg::TO_IDLE;
            end
          end
          default: begin
            to_state[c] <= ptc_pkg::TO_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel status

  // Acknowledges gather during a packet and publish at its end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      {acc_seen, acc_inv, ack_seen, ack_inv, to_flag} <= 10'h0;
    end else if (i_ce) begin
      for (int c = 0; c < 2; c++) begin
        if (ack_ev[c]) begin
          acc_seen[c] <= 1'b1;
          acc_inv[c]  <= ~evt_s2[c].ack_bit;
        end
        if (end_ev[c]) begin
          ack_seen[c] <= acc_seen[c] | ack_ev[c];
          ack_inv[c]  <= ack_ev[c] ? ~evt_s2[c].ack_bit : acc_inv[c];
          acc_seen[c] <= 1'b0;
        end
        // A new wait clears the old time-out; the firing cycle wins
        if (to_fire[c]) begin
          to_flag[c] <= 1'b1;
        end else if (to_state[c] == ptc_pkg::TO_IDLE && waiting[c]) begin
          to_flag[c] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers and interrupt

  // Status word has no write path at all, so writes there change nothing
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rate_code   <= ptc_pkg::RATE_RST;
      rate_double <= 1'b0;
      to_sel      <= ptc_pkg::TO_SEL_RST;
      {pt_en, xover, exchange} <= 5'h0;
      irq_mask    <= ptc_pkg::MASK_RST;
      irq_status  <= 4'h0;
      o_irq       <= 1'b0;
    end else if (i_ce) begin
      if (wr_cfg) begin
        rate_code   <= w_data[ptc_pkg::CFG_RATE_LSB +: 3];
        rate_double <= w_data[ptc_pkg::CFG_DBL_BIT];
        to_sel      <= w_data[ptc_pkg::CFG_TO_LSB +: 3];
      end
      if (wr_route) begin
        exchange <= w_data[ptc_pkg::RT_SWAP_BIT];
        xover    <= w_data[ptc_pkg::RT_XOVER_LSB +: 2];
        pt_en    <= w_data[ptc_pkg::RT_EN_LSB +: 2];
      end
      if (wr_mask) begin
        irq_mask <= w_data[3:0];
      end
      // Set beats the read-clear in the same cycle
      irq_status <= (irq_status & ~{4{rd_clear}}) | {end_ev, to_fire};
      o_irq      <= |(irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshakes

  // One write and one read in flight; address and data accepted in either order
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      {o_axi_awready, o_axi_wready, o_axi_arready} <= 3'h7;
      {o_axi_bvalid, o_axi_rvalid} <= 2'h0;
      o_axi_bresp <= ptc_pkg::RESP_OKAY;
      o_axi_rresp <= ptc_pkg::RESP_OKAY;
      o_axi_rdata <= 32'h0;
      aw_addr     <= 8'h0;
      w_data      <= 32'h0;
      w_strb      <= 4'h0;
    end else if (i_ce) begin
      if (aw_fire) begin
        o_axi_awready <= 1'b0;
        aw_addr       <= i_axi_awaddr;
      end
      if (w_fire) begin
        o_axi_wready <= 1'b0;
        w_data       <= i_axi_wdata;
        w_strb       <= i_axi_wstrb;
      end
      if (wr_go) begin
        o_axi_bvalid <= 1'b1;
        o_axi_bresp  <= addr_known(aw_addr) ? ptc_pkg::RESP_OKAY : ptc_pkg::RESP_SLVERR;
      end else if (o_axi_bvalid && i_axi_bready) begin
        o_axi_bvalid  <= 1'b0;
        o_axi_awready <= 1'b1;
        o_axi_wready  <= 1'b1;
      end
      if (ar_fire) begin
        o_axi_arready <= 1'b0;
        o_axi_rvalid  <= 1'b1;
        o_axi_rdata   <= rd_word;
        o_axi_rresp   <= addr_known(i_axi_araddr) ? ptc_pkg::RESP_OKAY : ptc_pkg::RESP_SLVERR;
      end else if (o_axi_rvalid && i_axi_rready) begin
        o_axi_rvalid  <= 1'b0;
        o_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin and channel outputs

  // Registered so every pin change is glitch-free; open-drain drives low only
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_pin_out    <= '0;
      o_pin_oe_n   <= '1;
      o_cc_drive_n <= '1;
      o_chan_line  <= '1;
    end else if (i_ce) begin
      o_pin_out    <= '0;
      o_pin_oe_n   <= next_pin_oe_n;
      o_cc_drive_n <= next_cc_drive_n;
      o_chan_line  <= next_chan_line;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking chk_clk @(posedge i_clk); endclocking
  default disable iff (i_reset);

  chk_rate_tick: assert property (i_ce && rate_wrap |=> o_main_bit_tick && rate_cnt == $past(half_sel) - 15'h1)
    else $error("bit tick or reload wrong");
  chk_rate_double: assert property (i_ce && rate_wrap && rate_double
    |=> rate_cnt == ($past(half_raw) >> 1) - 15'h1)
    else $error("doubled rate wrong");
  chk_to_expire: assert property (i_ce && to_fire[0] |=> to_state[0] == ptc_pkg::TO_EXPIRED && o_bus_release[0])
    else $error("time-out did not expire");
  chk_to_disabled: assert property (i_ce && to_sel == ptc_pkg::TO_DISABLED |=> o_bus_release == 2'h0)
    else $error("disabled time-out fired");
  chk_to_flag: assert property (o_bus_release[1] |-> to_flag[1])
    else $error("time-out flag missing");
  chk_ack_update: assert property (i_ce && end_ev[0] && !ack_ev[0] && acc_seen[0]
    |=> ack_seen[0] && ack_inv[0] == $past(acc_inv[0]))
    else $error("ack status not updated");
  chk_ack_capture: assert property (i_ce && ack_ev[0] |=> acc_inv[0] == ~$past(evt_s2[0].ack_bit))
    else $error("ack not captured inverted");
  // A new wait may clear a time-out flag in the same cycle, so that case is left out
  chk_status_ro: assert property (i_ce && wr_go && aw_word == ptc_pkg::ADDR_STATUS && !link_edge &&
    to_fire == 2'h0 && waiting == 2'h0 |=> $stable(status_word))
    else $error("status changed by write");
  chk_swap_route: assert property (i_ce && exchange && !gate[0] && !xover[0] && !i_chan_drive_n[0].sda
    |=> !o_pin_oe_n[1].sda)
    else $error("exchange not applied");
  chk_xover_off: assert property (i_ce && xover == 2'h0 |=> o_cc_drive_n == 2'b11)
    else $error("control channel driven");
  chk_release_bus: assert property (i_ce && expired[0] && !exchange |=> o_pin_oe_n[0] == 2'b11)
    else $error("bus not released");
  chk_irq_level: assert property (i_ce && |(irq_status & irq_mask) |=> o_irq)
    else $error("interrupt missing");

endmodule

`default_nettype wire

// File: design/ptc_pkg.sv
// Purpose: Shared constants and types for the pass-through I2C remote main control block
// Assumes: 200 MHz system clock, AXI4-Lite register access with 32-bit data
// Notes:   Register words sit at aligned byte addresses; unused bits read as zero
package ptc_pkg;

  // Clock and time base
  localparam int CLK_HZ        = 200_000_000;
  localparam int CLK_PERIOD_NS = 5;

  // Bit rates of the remote main, one per rate code
  localparam int RATE_BPS [8] = '{9_920, 33_200, 99_200, 123_000, 203_000, 397_000, 625_000, 980_000};

  // Time-out base durations
  localparam int TO_16US_NS  = 16_000;
  localparam int TO_1MS_NS   = 1_000_000;
  localparam int TO_16US_CYC = TO_16US_NS / CLK_PERIOD_NS;
  localparam int TO_1MS_CYC  = TO_1MS_NS / CLK_PERIOD_NS;
  localparam int HALF0_CYC   = (CLK_HZ + 2 * RATE_BPS[0] - 1) / (2 * RATE_BPS[0]);
  localparam logic [2:0] TO_DISABLED = 3'h7;

  // Register byte offsets
  localparam logic [7:0] ADDR_MAIN_CFG   = 8'h00;
  localparam logic [7:0] ADDR_ROUTE      = 8'h04;
  localparam logic [7:0] ADDR_STATUS     = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h10;

  // Field positions, main configuration word
  localparam int CFG_RATE_LSB = 0;
  localparam int CFG_DBL_BIT  = 3;
  localparam int CFG_TO_LSB   = 4;
  // Field positions, routing word
  localparam int RT_SWAP_BIT  = 0;
  localparam int RT_XOVER_LSB = 1;
  localparam int RT_EN_LSB    = 3;

  // Values after reset
  localparam logic [2:0] RATE_RST   = 3'h0;
  localparam logic [2:0] TO_SEL_RST = 3'h1;
  localparam logic [3:0] MASK_RST   = 4'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One open-drain line pair
  typedef struct packed {
    logic sda;
    logic scl;
  } i2c_line_type;

  // Per-channel events from the link packet engine
  typedef struct packed {
    logic wait_resp;
    logic ack_valid;
    logic ack_bit;
    logic pkt_end;
  } link_evt_type;

  // Time-out watcher states, Gray along idle-count-expired
  typedef enum logic [1:0] {
    TO_IDLE    = 2'b00,
    TO_COUNT   = 2'b01,
    TO_EXPIRED = 2'b11
  } to_state_type;

endpackage

// File: test/ptc_remote_peer.sv
// Purpose: Remote I2C peripheral on the pass-through pins
// Assumes: Open-drain lines with pull-ups
// Notes:   Stretches the clock line on command
`timescale 1ns/100ps
`default_nettype none
module ptc_remote_peer (
  // Enables from the block, stretch command
  input  wire ptc_pkg::i2c_line_type [1:0] i_oe_n,
  input  wire logic [1:0]                  i_stretch,
  // Resolved line levels
  output ptc_pkg::i2c_line_type [1:0]      o_line
);
  // Pull-up wins unless a party pulls low; never acts as a main
  assign o_line[0] = {i_oe_n[0].sda, i_oe_n[0].scl & ~i_stretch[0]};
  assign o_line[1] = {i_oe_n[1].sda, i_oe_n[1].scl & ~i_stretch[1]};
endmodule
`default_nettype wire

// File: test/passthrough_i2c_remote_main_ctrl_bench.sv
// Purpose: Self-checking bench for the remote main control block
// Assumes: Half period 8 cycles, 1 ms shortened to 50 cycles
// Notes:   Registers over AXI4-Lite; link clock 125 ns
`timescale 1ns/100ps
`default_nettype none
module passthrough_i2c_remote_main_ctrl_bench;
  logic i_clk = 0, i_reset = 1, i_ce = 1, i_link_clk = 0;
  logic i_axi_awvalid = 0, i_axi_wvalid = 0, i_axi_bready = 0, i_axi_arvalid = 0, i_axi_rready = 0;
  logic [7:0] i_axi_awaddr = 0, i_axi_araddr = 0;
  logic [31:0] i_axi_wdata = 0, o_axi_rdata;
  logic [3:0] i_axi_wstrb = 4'hf;
  logic [1:0] stretch = 2'h1, rr, br, o_axi_bresp, o_axi_rresp, o_bus_release;
  ptc_pkg::link_evt_type [1:0] i_link_evt = '0;
  ptc_pkg::i2c_line_type [1:0] i_pin, o_pin_out, o_pin_oe_n, i_chan_drive_n = '1, o_chan_line;
  ptc_pkg::i2c_line_type i_cc_line, o_cc_drive_n;
  logic o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid, o_main_bit_tick, o_irq;
  int err_count = 0, checks_done = 0, n;
  assign i_cc_line = o_cc_drive_n; // Pulled-up control channel
  always #2.5 i_clk = ~i_clk;
  always #62.5 i_link_clk = ~i_link_clk;
  passthrough_i2c_remote_main_ctrl #(.RATE0_HALF_CYC(8), .TO_1MS_CYCLES(50)) i_passthrough_i2c_remote_main_ctrl (
    .i_clk, .i_reset, .i_ce, .i_axi_awvalid, .o_axi_awready, .i_axi_awaddr, .i_axi_wvalid, .o_axi_wready,
    .i_axi_wdata, .i_axi_wstrb, .o_axi_bvalid, .i_axi_bready, .o_axi_bresp, .i_axi_arvalid, .o_axi_arready,
    .i_axi_araddr, .o_axi_rvalid, .i_axi_rready, .o_axi_rdata, .o_axi_rresp, .i_link_clk, .i_link_evt, .i_pin,
    .o_pin_out, .o_pin_oe_n, .i_cc_line, .o_cc_drive_n, .i_chan_drive_n, .o_chan_line, .o_main_bit_tick,
    .o_bus_release, .o_irq);
  ptc_remote_peer i_ptc_remote_peer (.i_oe_n(o_pin_oe_n), .i_stretch(stretch), .o_line(i_pin));
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    end
  endtask
  // Address and data offered together; both readies are up when idle
  // Each of address and data is released at the edge at which it is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_left, w_left;
    {aw_left, w_left} = 2'h3;
    @(posedge i_clk);
    {i_axi_awvalid, i_axi_wvalid, i_axi_bready, i_axi_awaddr, i_axi_wdata} <= {3'h7, a, d};
    do begin
      @(posedge i_clk);
      aw_left = aw_left && !o_axi_awready;
      w_left  = w_left && !o_axi_wready;
      i_axi_awvalid <= aw_left;
      i_axi_wvalid  <= w_left;
    end while (aw_left || w_left);
    do @(posedge i_clk); while (!o_axi_bvalid);
    i_axi_bready <= 0;
    br = o_axi_bresp;
  endtask
  task automatic rdchk(input string s, input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    {i_axi_arvalid, i_axi_rready, i_axi_araddr} <= {2'h3, a};
    do @(posedge i_clk); while (!o_axi_arready);
    i_axi_arvalid <= 0;
    do @(posedge i_clk); while (!o_axi_rvalid);
    i_axi_rready <= 0;
    rr = o_axi_rresp;
    chk(s, o_axi_rdata, e);
  endtask
  // Cycles between two half-bit ticks
  task automatic tick(input logic [31:0] e);
    do @(posedge i_clk); while (!o_main_bit_tick);
    n = 0;
    do begin @(posedge i_clk); n++; end while (!o_main_bit_tick);
    chk("tick", n, e);
  endtask
  // Fields change while the link clock is low, stable over its rise
  task automatic pkt(input int c, input logic a);
    @(negedge i_link_clk); @(posedge i_clk);
    {i_link_evt[c].ack_valid, i_link_evt[c].ack_bit} <= {1'b1, a};
    @(negedge i_link_clk); @(posedge i_clk);
    {i_link_evt[c].ack_valid, i_link_evt[c].pkt_end} <= 2'h1;
    @(negedge i_link_clk); @(posedge i_clk);
    i_link_evt[c].pkt_end <= 0;
    repeat (8) @(posedge i_clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_reset <= 0;
    rdchk("cfg", 8'h00, 32'h10);
    wr(8'h00, 32'h08);
    tick(32'h4);
    wr(8'h00, 32'h07);
    tick(32'h67);
    wr(8'h00, 32'h00);
    tick(32'h8);
    rdchk("unmapped", 8'h14, 32'h0);
    chk("resp", rr, 32'h2);
    $display("test registers done");
    wr(8'h10, 32'h4);
    pkt(0, 1'b0);
    chk("irq", o_irq, 32'h1);
    pkt(1, 1'b1);
    rdchk("status", 8'h08, 32'h23);
    rdchk("irq status", 8'h0c, 32'hc);
    rdchk("irq status", 8'h0c, 32'h0);
    chk("irq", o_irq, 32'h0);
    $display("test status done");
    n = 0;
    i_link_evt[1].wait_resp <= 1;
    do begin @(posedge i_clk); n++; end while (!o_bus_release[1] && n < 5000);
    chk("timeout", n >= 3200 && n < 3210, 32'h1);
    i_link_evt[1].wait_resp <= 0;
    wr(8'h08, 32'hffffffff);
    chk("status bresp", br, 32'h0);
    rdchk("status", 8'h08, 32'h63);
    wr(8'h00, 32'h20);
    n = 0;
    i_link_evt[0].wait_resp <= 1;
    do begin @(posedge i_clk); n++; end while (!o_bus_release[0] && n < 500);
    chk("timeout 2ms", n >= 100 && n < 110, 32'h1);
    i_link_evt[0].wait_resp <= 0;
    wr(8'h00, 32'h70);
    n = 0;
    i_link_evt[0].wait_resp <= 1;
    do begin @(posedge i_clk); n++; end while (!o_bus_release[0] && n < 400);
    chk("timeout off", n, 32'h190);
    i_link_evt[0].wait_resp <= 0;
    $display("test timeout done");
    i_chan_drive_n[0].sda <= 0;
    wr(8'h04, 32'h08);
    repeat (4) @(posedge i_clk);
    chk("pins", {o_pin_oe_n, o_chan_line[0].scl}, 32'h1a);
    chk("pin out", o_pin_out, 32'h0);
    wr(8'h04, 32'h19);
    repeat (4) @(posedge i_clk);
    chk("swap", {o_pin_oe_n, o_chan_line[0].scl}, 32'h0f);
    wr(8'h04, 32'h0a);
    repeat (4) @(posedge i_clk);
    chk("cross", {o_pin_oe_n, o_cc_drive_n}, 32'h3d);
    $display("test pins done");
    wrap_up;
  end
  initial begin
    #100us;
    err_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
